// ==== pcfm_pkg.sv ====
// Purpose: Shared constants and types for the port clock frequency meter
// Assumes: Byte-wide configuration access, one clock domain
// Notes: Offsets are configuration-space byte addresses
package pcfm_pkg;

  // Configuration-space byte offsets
  localparam logic [7:0] TIMER_CONTROL_OFS = 8'h61;
  localparam logic [7:0] EDGE_COUNT_LO_OFS = 8'h62;
  localparam logic [7:0] EDGE_COUNT_HI_OFS = 8'h63;

  // Field positions inside timer_control
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SOURCE_BIT = 1;
  localparam int CTRL_SOURCE_HI_BIT = 2;
  localparam int CTRL_STOP_BIT = 3;
  localparam int CTRL_PERIOD_LSB = 4;
  localparam int CTRL_PERIOD_MSB = 5;

  // Reset values
  localparam logic [1:0] PERIOD_RESET = 2'h0;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Period code 0 gives this many reference high phases; each code step doubles it
  localparam logic [7:0] BASE_WINDOWS = 8'h10;
  localparam logic [7:0] WINDOW_STEP = 8'h01;
  localparam int WINDOW_WIDTH = 8;

  // Source select encodings
  localparam logic SOURCE_PRIMARY = 1'b0;
  localparam logic SOURCE_SECONDARY = 1'b1;

  // Pin synchroniser lanes
  localparam int PIN_COUNT = 3;
  localparam int PIN_TIMEBASE = 0;
  localparam int PIN_PRIMARY = 1;
  localparam int PIN_SECONDARY = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcfm_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } pcfm_cfg_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_COUNT,
    ST_DONE
  } pcfm_state_t;

endpackage : pcfm_pkg

// ==== pcfm_meter.sv ====
// Purpose: Port clock frequency meter, counts measured-clock edges inside reference high phases
// Assumes: All three clock pins are slow enough to be oversampled by the 100 MHz system clock
// Notes:
`timescale 1ns/10ps
`default_nettype none

module pcfm_meter #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire pcfm_pkg::pcfm_cfg_req_t cfgReq,
  output pcfm_pkg::pcfm_cfg_rsp_t cfgRsp,
  input wire logic timebaseClockIn,
  input wire logic primaryPortClock,
  input wire logic secondaryPortClock,
  output logic runActive
);

  logic [pcfm_pkg::PIN_COUNT-1:0] pinRaw;
  logic [pcfm_pkg::PIN_COUNT-1:0] pinMeta_reg;
  logic [pcfm_pkg::PIN_COUNT-1:0] pinSync_reg;
  logic [pcfm_pkg::PIN_COUNT-1:0] pinPrev_reg;

  logic enable_reg;
  logic sourceSel_reg;
  logic [1:0] period_reg;
  logic stop_reg;
  pcfm_pkg::pcfm_state_t state_reg;
  pcfm_pkg::pcfm_state_t state_next;
  logic [pcfm_pkg::WINDOW_WIDTH-1:0] windowCnt_reg;
  logic [COUNT_WIDTH-1:0] edgeCount_reg;
  logic rspValid_reg;
  logic [7:0] rspData_reg;
  logic runActive_reg;

  logic ctrlWrite;
  logic startRun;
  logic abortRun;
  logic refLevel;
  logic refFall;
  logic measRise;
  logic lastWindow;
  logic countSat;
  logic [pcfm_pkg::WINDOW_WIDTH-1:0] windowLast;
  logic [7:0] controlView;
  logic [7:0] readValue;

  assign pinRaw[pcfm_pkg::PIN_TIMEBASE] = timebaseClockIn;
  assign pinRaw[pcfm_pkg::PIN_PRIMARY] = primaryPortClock;
  assign pinRaw[pcfm_pkg::PIN_SECONDARY] = secondaryPortClock;

  // Clock pins are sampled, not used as clocks: a single clock domain keeps the
  // count and registers trivially coherent, at the cost of an upper frequency limit.
  genvar gi;
  generate
    for (gi = 0; gi < pcfm_pkg::PIN_COUNT; gi++)
    begin : g_pinSync
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          pinMeta_reg[gi] <= 1'b0;
          pinSync_reg[gi] <= 1'b0;
          pinPrev_reg[gi] <= 1'b0;
        end
        else
        begin
          pinMeta_reg[gi] <= pinRaw[gi];
          pinSync_reg[gi] <= pinMeta_reg[gi];
          pinPrev_reg[gi] <= pinSync_reg[gi];
        end
      end
    end
  endgenerate

  // Windows come only from the dedicated reference pin
  assign refLevel = pinSync_reg[pcfm_pkg::PIN_TIMEBASE];
  assign refFall = pinPrev_reg[pcfm_pkg::PIN_TIMEBASE] & ~pinSync_reg[pcfm_pkg::PIN_TIMEBASE];

  always_comb
  begin
    if (sourceSel_reg == pcfm_pkg::SOURCE_SECONDARY)
    begin
      measRise = pinSync_reg[pcfm_pkg::PIN_SECONDARY] & ~pinPrev_reg[pcfm_pkg::PIN_SECONDARY];
    end
    else
    begin
      measRise = pinSync_reg[pcfm_pkg::PIN_PRIMARY] & ~pinPrev_reg[pcfm_pkg::PIN_PRIMARY];
    end
  end

  // 16 << code gives 16, 32, 64 or 128 windows
  assign windowLast = (pcfm_pkg::BASE_WINDOWS << period_reg) - pcfm_pkg::WINDOW_STEP;
  assign lastWindow = (windowCnt_reg == windowLast);
  assign countSat = &edgeCount_reg;

  assign ctrlWrite = cfgReq.wr && (cfgReq.addr == pcfm_pkg::TIMER_CONTROL_OFS);
  // Only a 0-to-1 change of enable starts a run
  assign startRun = ctrlWrite && cfgReq.wdata[pcfm_pkg::CTRL_ENABLE_BIT] && !enable_reg;
  assign abortRun = ctrlWrite && !cfgReq.wdata[pcfm_pkg::CTRL_ENABLE_BIT];

  // Control register fields written by software
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_reg <= 1'b0;
      sourceSel_reg <= pcfm_pkg::SOURCE_PRIMARY;
      period_reg <= pcfm_pkg::PERIOD_RESET;
    end
    else if (ctrlWrite)
    begin
      // Enable holds whatever software wrote; completion never clears it
      enable_reg <= cfgReq.wdata[pcfm_pkg::CTRL_ENABLE_BIT];
      sourceSel_reg <= cfgReq.wdata[pcfm_pkg::CTRL_SOURCE_BIT];
      period_reg <= cfgReq.wdata[pcfm_pkg::CTRL_PERIOD_MSB:pcfm_pkg::CTRL_PERIOD_LSB];
    end
  end

  // Run sequencer
  always_comb
  begin
    state_next = state_reg;
    if (abortRun)
    begin
      state_next = pcfm_pkg::ST_IDLE;
    end
    else if (startRun)
    begin
      state_next = pcfm_pkg::ST_ARM;
    end
    else
    begin
      unique case (state_reg)
        pcfm_pkg::ST_IDLE:
        begin
          state_next = pcfm_pkg::ST_IDLE;
        end
        pcfm_pkg::ST_ARM:
        begin
          // Wait for reference low so the first window is a whole high phase
          if (!refLevel)
          begin
            state_next = pcfm_pkg::ST_COUNT;
          end
        end
        pcfm_pkg::ST_COUNT:
        begin
          if (refFall && lastWindow)
          begin
            state_next = pcfm_pkg::ST_DONE;
          end
        end
        pcfm_pkg::ST_DONE:
        begin
          state_next = pcfm_pkg::ST_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= pcfm_pkg::ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Completed window count, advanced on each reference falling edge in ST_COUNT until the last window
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      windowCnt_reg <= '0;
    end
    else if (startRun)
    begin
      windowCnt_reg <= '0;
    end
    else if (state_reg == pcfm_pkg::ST_COUNT && refFall && !lastWindow)
    begin
      windowCnt_reg <= windowCnt_reg + pcfm_pkg::WINDOW_STEP;
    end
  end

  // Edge accumulator; saturates rather than wrapping so an overrange shows as all ones
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      edgeCount_reg <= '0;
    end
    else if (startRun)
    begin
      edgeCount_reg <= '0;
    end
    else if (state_reg == pcfm_pkg::ST_COUNT && refLevel && measRise && !countSat)
    begin
      edgeCount_reg <= edgeCount_reg + COUNT_WIDTH'(1);
    end
  end

  // Stop flag: cleared by a new start, set when the last window closes
  // A start needs enable low, which forces idle, so start and set never meet
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_reg <= 1'b0;
    end
    else if (startRun)
    begin
      stop_reg <= 1'b0;
    end
    else if (state_reg == pcfm_pkg::ST_COUNT && refFall && lastWindow && !abortRun)
    begin
      stop_reg <= 1'b1;
    end
  end

  // Registered so the status pin carries no decode glitches
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      runActive_reg <= 1'b0;
    end
    else
    begin
      runActive_reg <= (state_next == pcfm_pkg::ST_ARM) || (state_next == pcfm_pkg::ST_COUNT);
    end
  end

  assign runActive = runActive_reg;

  always_comb
  begin
    controlView = pcfm_pkg::READ_IDLE;
    controlView[pcfm_pkg::CTRL_ENABLE_BIT] = enable_reg;
    controlView[pcfm_pkg::CTRL_SOURCE_BIT] = sourceSel_reg;
    controlView[pcfm_pkg::CTRL_SOURCE_HI_BIT] = 1'b0;
    controlView[pcfm_pkg::CTRL_STOP_BIT] = stop_reg;
    controlView[pcfm_pkg::CTRL_PERIOD_MSB:pcfm_pkg::CTRL_PERIOD_LSB] = period_reg;
  end

  // Count bytes are not latched together; read them only once stop is set
  always_comb
  begin
    unique case (cfgReq.addr)
      pcfm_pkg::TIMER_CONTROL_OFS: readValue = controlView;
      pcfm_pkg::EDGE_COUNT_LO_OFS: readValue = edgeCount_reg[7:0];
      pcfm_pkg::EDGE_COUNT_HI_OFS: readValue = edgeCount_reg[COUNT_WIDTH-1:8];
      default: readValue = pcfm_pkg::READ_IDLE;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rspValid_reg <= 1'b0;
      rspData_reg <= pcfm_pkg::READ_IDLE;
    end
    else
    begin
      rspValid_reg <= cfgReq.rd;
      if (cfgReq.rd)
      begin
        rspData_reg <= readValue;
      end
    end
  end

  assign cfgRsp.valid = rspValid_reg;
  assign cfgRsp.rdata = rspData_reg;

endmodule : pcfm_meter

`default_nettype wire

// ==== pcfm_meter_props.sv ====
// Purpose: Port checks for the frequency meter
// Assumes: One clock domain
// Notes: Tracks enable from control writes
`timescale 1ns/10ps
`default_nettype none
module pcfm_meter_props (
  input wire logic clock,
  input wire logic nrst,
  input wire pcfm_pkg::pcfm_cfg_req_t cfgReq,
  input wire pcfm_pkg::pcfm_cfg_rsp_t cfgRsp,
  input wire logic runActive
);
  logic ctlWr;
  logic enReg;
  logic startReg;
  logic ctlRdReg;
  assign ctlWr = cfgReq.wr && cfgReq.addr == pcfm_pkg::TIMER_CONTROL_OFS;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      enReg <= 1'b0;
    else if (ctlWr)
      enReg <= cfgReq.wdata[0];
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      startReg <= 1'b0;
    else
      startReg <= ctlWr && cfgReq.wdata[0] && !enReg;
  end
  // Mixed read and write left out: order not fixed
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ctlRdReg <= 1'b0;
    else
      ctlRdReg <= cfgReq.rd && !cfgReq.wr && cfgReq.addr == pcfm_pkg::TIMER_CONTROL_OFS;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_rsp_after_rd: assert property (cfgReq.rd |=> cfgRsp.valid)
    else $error("read not answered");
  a_valid_only_rd: assert property (cfgRsp.valid |-> $past(cfgReq.rd))
    else $error("answer without read");
  a_src_hi_zero: assert property (ctlRdReg |-> cfgRsp.rdata[2] == 1'b0 && cfgRsp.rdata[7:6] == 2'h0)
    else $error("reserved control bits set");
  a_start_arms: assert property (startReg |-> runActive)
    else $error("start did not arm");
  a_disable_abort: assert property (ctlWr && !cfgReq.wdata[0] |=> !runActive)
    else $error("disable left run active");
  a_rise_needs_start: assert property ($rose(runActive) |-> startReg)
    else $error("run began without start");
  a_en_readback: assert property (ctlRdReg |-> cfgRsp.rdata[0] == $past(enReg))
    else $error("enable readback wrong");
  a_stop_idle: assert property (ctlRdReg && cfgRsp.rdata[3] |-> !$past(runActive))
    else $error("stop while running");
  c_start: cover property (startReg);
  c_finish: cover property ($fell(runActive));
  c_stop_read: cover property (ctlRdReg && cfgRsp.rdata[3]);
endmodule : pcfm_meter_props
bind pcfm_meter pcfm_meter_props i_props (.clock(clock), .nrst(nrst), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
  .runActive(runActive));
`default_nettype wire

// ==== port_clock_frequency_meter_tb_top.sv ====
// Purpose: Self-checking bench for the frequency meter
// Assumes: Pin clocks made from a cycle counter
// Notes: Windows 20 cycles high; edges kept 2 cycles off borders
`timescale 1ns/10ps
`default_nettype none
module port_clock_frequency_meter_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  pcfm_pkg::pcfm_cfg_req_t cfgReq = '0;
  pcfm_pkg::pcfm_cfg_rsp_t cfgRsp;
  logic timebase_clock_in = 1'b0;
  logic primClk = 1'b0;
  logic secClk = 1'b0;
  logic runActive;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int pP = 4;
  int pS = 5;
  logic [7:0] lf = 8'h2d;
  logic [15:0] rdv;
  logic [15:0] cnt;
  logic timedOut = 1'b0;
  pcfm_meter i_dut (.clock(clock), .nrst(nrst), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .timebaseClockIn(timebase_clock_in),
    .primaryPortClock(primClk), .secondaryPortClock(secClk), .runActive(runActive));
  initial forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    // Fixed 2.5 MHz reference, far slower than either port clock
    timebase_clock_in <= (cyc % 40) < 20;
    primClk <= ((cyc + pP - 2) % pP) < pP / 2;
    secClk <= ((cyc + pS - 2) % pS) < pS / 2;
  end
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  // 20-cycle high phases, measured edges kept 2 cycles clear of their borders
  function automatic logic [15:0] expEdges(input int per, input int p);
    return 16'(((16 << per) * 20) / p);
  endfunction : expEdges
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrC(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfgReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    cfgReq.wr <= 1'b0;
  endtask : wrC
  task automatic rdC(input logic [7:0] a);
    @(posedge clock);
    cfgReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    cfgReq.rd <= 1'b0;
    // Answer stands only for the cycle after the request edge
    #1;
    chk(cfgRsp.valid, 1'b1);
    rdv = {8'h00, cfgRsp.rdata};
  endtask : rdC
  initial
  begin
    int per;
    int src;
    int k;
    int p [3] = '{4, 5, 10};
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    for (k = 8'h60; k < 8'h64; k++)
    begin
      rdC(k[7:0]);
      chk(rdv, 16'h0000);
    end
    wrC(8'h61, 8'hff);
    rdC(8'h61);
    chk(rdv, 16'h0033);
    wrC(8'h61, 8'h32);
    rdC(8'h61);
    chk(rdv, 16'h0032);
    chk(runActive, 1'b0);
    for (per = 0; per < 4 && !timedOut; per++)
      for (src = 0; src < 2 && !timedOut; src++)
      begin
        lf = nxt(lf);
        k = lf % 3;
        pP = p[k];
        lf = nxt(lf);
        // Distinct rates so a wrong source shows
        pS = p[(k + 1 + lf % 2) % 3];
        wrC(8'h61, {2'h0, per[1:0], 2'h0, src[0], 1'b0});
        wrC(8'h61, {2'h0, per[1:0], 2'h0, src[0], 1'b1});
        wrC(8'h62, lf);
        k = 0;
        do
        begin
          rdC(8'h61);
          k++;
        end
        while (rdv[3] !== 1'b1 && k < 3000);
        if (k >= 3000)
        begin
          n_errors++;
          timedOut = 1'b1;
        end
        else
        begin
          chk(rdv, {10'h000, per[1:0], 2'b10, src[0], 1'b1});
          chk(runActive, 1'b0);
          rdC(8'h62);
          cnt = rdv;
          rdC(8'h63);
          cnt[15:8] = rdv[7:0];
          chk(cnt, expEdges(per, src ? pS : pP));
          wrC(8'h61, {2'h0, per[1:0], 2'h0, src[0], 1'b1});
          rdC(8'h61);
          chk(rdv[3], 1'b1);
        end
      end
    conclude();
  end
endmodule : port_clock_frequency_meter_tb_top
`default_nettype wire
